// ==== common/dnc_pkg.sv ====
// Constants and types of the DSP node data capture unit.
// Assumes a 50 MHz core clock and an SPI host using mode 0 framing.
package dnc_pkg;

    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int STEP_W = 9;
    localparam int SEL_W = 2;
    localparam int SETUP_W = STEP_W + SEL_W;
    localparam int DATA_W = 24;
    localparam int NUM_CAP = 4;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [9:0] CAP_HOST_ONE = 10'h105;
    localparam logic [9:0] CAP_HOST_TWO = 10'h106;
    localparam logic [9:0] CAP_SER_ONE = 10'h107;
    localparam logic [9:0] CAP_SER_TWO = 10'h108;
    localparam logic [10:0] SETUP_RST = 11'h000;
    localparam logic [23:0] CAP_RST = 24'h000000;

    // --------------------------------------------------------------
    // SPI frame layout
    // --------------------------------------------------------------
    localparam int HDR_RW_POS = 2;
    localparam int BYTE_HDR = 0;
    localparam int BYTE_ADDR = 1;
    localparam int BYTE_DHI = 2;
    localparam int BYTE_DLO = 3;
    localparam logic [7:0] PAD_BYTE = 8'h00;

    typedef enum logic [1:0] {
        DNC_SRC_PRODUCT,
        DNC_SRC_DECIBEL,
        DNC_SRC_DATA_OP,
        DNC_SRC_COEF_OP
    } dnc_src_t;

endpackage : dnc_pkg

// ==== design/dnc_serial_out.sv ====
// Serial output of the two streamed capture words, bit clock domain.
// Assumes word select changes on the falling bit clock edge, as the
// main serial inputs do, so it needs no synchroniser here.
`timescale 1ns/1ns
module dnc_serial_out
    import dnc_pkg::*;
(
    // Link clock and framing
    input wire logic bclk_i,
    input wire logic lrclk_i,
    // Reset from the core domain
    input wire logic rst_n_i,
    // Words from the core domain, stable while req differs from ack
    input wire logic [dnc_pkg::DATA_W-1:0] left_i,
    input wire logic [dnc_pkg::DATA_W-1:0] right_i,
    input wire logic req_i,
    output logic ack_o,
    // Serial pin
    output logic sdo_o
);

    logic rst_m;
    logic rst_s;
    logic req_m;
    logic req_s;
    logic lr_prev;
    logic [DATA_W-1:0] left_w;
    logic [DATA_W-1:0] right_w;
    logic [DATA_W-1:0] shift;

    // ------------------------------------------------------------
    // Reset and request crossing
    // ------------------------------------------------------------
    always_ff @(negedge bclk_i)
    begin
        rst_m <= rst_n_i;
        rst_s <= rst_m;
    end

    always_ff @(negedge bclk_i)
    begin
        if (!rst_s)
        begin
            req_m <= 1'b0;
            req_s <= 1'b0;
        end
        else
        begin
            req_m <= req_i;
            req_s <= req_m;
        end
    end

    // Words are only taken while the core side holds them still
    always_ff @(negedge bclk_i)
    begin
        if (!rst_s)
        begin
            ack_o <= 1'b0;
            left_w <= CAP_RST;
            right_w <= CAP_RST;
        end
        else if (req_s != ack_o)
        begin
            left_w <= left_i;
            right_w <= right_i;
            ack_o <= req_s;
        end
    end

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    // The change of word select is seen one edge late, which gives the
    // one bit delay of the input format for free.
    always_ff @(negedge bclk_i)
    begin
        if (!rst_s)
        begin
            lr_prev <= 1'b0;
            shift <= CAP_RST;
            sdo_o <= 1'b0;
        end
        else
        begin
            lr_prev <= lrclk_i;
            if (lrclk_i != lr_prev)
            begin
                // Low word select is the left slot
                if (!lrclk_i)
                begin
                    sdo_o <= left_w[DATA_W-1];
                    shift <= {left_w[DATA_W-2:0], 1'b0};
                end
                else
                begin
                    sdo_o <= right_w[DATA_W-1];
                    shift <= {right_w[DATA_W-2:0], 1'b0};
                end
            end
            else
            begin
                sdo_o <= shift[DATA_W-1];
                shift <= {shift[DATA_W-2:0], 1'b0};
            end
        end
    end

endmodule : dnc_serial_out

// ==== design/dnc_capture.sv ====
// Data capture unit: trap logic, SPI setup and read port, serial feed.
// Assumes core program counter and source registers on ref_clk_i, and
// SPI pins and the serial bit clock from outside this clock domain.
`timescale 1ns/1ns
module dnc_capture
    import dnc_pkg::*;
(
    // Core clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // DSP core taps
    input wire logic step_valid_i,
    input wire logic [dnc_pkg::STEP_W-1:0] prog_counter_i,
    input wire logic [dnc_pkg::DATA_W-1:0] mult_product_i,
    input wire logic [dnc_pkg::DATA_W-1:0] decibel_conversion_result_i,
    input wire logic [dnc_pkg::DATA_W-1:0] multiplier_data_operand_i,
    input wire logic [dnc_pkg::DATA_W-1:0] multiplier_coefficient_operand_i,
    // SPI pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Serial output link
    input wire logic bclk_i,
    input wire logic lrclk_i,
    output logic capture_serial_output_o
);

    logic [SETUP_W-1:0] setup [NUM_CAP];
    logic [DATA_W-1:0] cap [NUM_CAP];
    logic [DATA_W-1:0] next_src [NUM_CAP];

    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic mosi_m;
    logic mosi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_active;

    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] rx;
    logic [7:0] rx_full;
    logic byte_done;
    logic [7:0] hdr;
    logic [7:0] data_hi;
    logic [ADDR_W-1:0] addr;
    logic is_read;
    logic [31:0] tx;

    logic ser_req;
    logic ser_ack;
    logic ack_m;
    logic ack_s;
    logic [DATA_W-1:0] ser_left;
    logic [DATA_W-1:0] ser_right;

    // ------------------------------------------------------------
    // Trap logic
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CAP; gi++)
        begin : g_cap
            always_comb
            begin
                case (dnc_src_t'(setup[gi][SEL_W-1:0]))
                    DNC_SRC_PRODUCT:
                        next_src[gi] = mult_product_i;
                    DNC_SRC_DECIBEL:
                        next_src[gi] = decibel_conversion_result_i;
                    DNC_SRC_DATA_OP:
                        next_src[gi] = multiplier_data_operand_i;
                    DNC_SRC_COEF_OP:
                        next_src[gi] = multiplier_coefficient_operand_i;
                    default:
                        next_src[gi] = mult_product_i;
                endcase
            end

            // Holds its word between matching steps
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                begin
                    cap[gi] <= CAP_RST;
                end
                else if (step_valid_i && prog_counter_i == setup[gi][SETUP_W-1:SEL_W])
                begin
                    cap[gi] <= next_src[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // SPI pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
        end
        else
        begin
            sclk_m <= spi_sclk_i;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            cs_m <= spi_cs_n_i;
            cs_s <= cs_m;
            mosi_m <= spi_mosi_i;
            mosi_s <= mosi_m;
        end
    end

    assign sel_active = !cs_s;
    assign sclk_rise = sel_active && sclk_s && !sclk_d;
    assign sclk_fall = sel_active && !sclk_s && sclk_d;
    assign rx_full = {rx[6:0], mosi_s};
    assign byte_done = sclk_rise && (bit_cnt == 3'h7);

    // ------------------------------------------------------------
    // SPI receive framing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || !sel_active)
        begin
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            rx <= 8'h00;
        end
        else if (sclk_rise)
        begin
            rx <= rx_full;
            bit_cnt <= bit_cnt + 3'h1;
            // Saturates so long bursts never wrap into a new header
            if (bit_cnt == 3'h7 && byte_cnt != 3'h7)
            begin
                byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end

    // Header and address of the transfer in progress
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            hdr <= 8'h00;
            addr <= '0;
            is_read <= 1'b0;
            data_hi <= 8'h00;
        end
        else if (byte_done)
        begin
            case (byte_cnt)
                3'(BYTE_HDR):
                    hdr <= rx_full;
                3'(BYTE_ADDR):
                begin
                    addr <= {hdr[1:0], rx_full};
                    is_read <= hdr[HDR_RW_POS];
                end
                3'(BYTE_DHI):
                    data_hi <= rx_full;
                default:
                    data_hi <= data_hi;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Setup registers
    // ------------------------------------------------------------
    // Only the fourth byte of a write to 261..264 commits; other
    // addresses and later bytes leave the setup untouched.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NUM_CAP; i++)
            begin
                setup[i] <= SETUP_RST;
            end
        end
        else if (byte_done && byte_cnt == 3'(BYTE_DLO) && !is_read)
        begin
            case (addr)
                CAP_HOST_ONE:
                    setup[0] <= {data_hi[2:0], rx_full};
                CAP_HOST_TWO:
                    setup[1] <= {data_hi[2:0], rx_full};
                CAP_SER_ONE:
                    setup[2] <= {data_hi[2:0], rx_full};
                CAP_SER_TWO:
                    setup[3] <= {data_hi[2:0], rx_full};
                default:
                    setup[0] <= setup[0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // SPI read path
    // ------------------------------------------------------------
    // The word is frozen at address decode so a trap during the read
    // cannot tear the returned bytes.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || !sel_active)
        begin
            tx <= 32'h00000000;
        end
        else if (byte_done && byte_cnt == 3'(BYTE_ADDR))
        begin
            if (hdr[HDR_RW_POS] && {hdr[1:0], rx_full} == CAP_HOST_ONE)
            begin
                tx <= {PAD_BYTE, cap[0]};
            end
            else if (hdr[HDR_RW_POS] && {hdr[1:0], rx_full} == CAP_HOST_TWO)
            begin
                tx <= {PAD_BYTE, cap[1]};
            end
            else
            begin
                tx <= 32'h00000000;
            end
        end
        else if (sclk_fall)
        begin
            tx <= {tx[30:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || !sel_active)
        begin
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end
        else
        begin
            spi_miso_oe_o <= 1'b1;
            if (sclk_fall)
            begin
                spi_miso_o <= tx[31];
            end
        end
    end

    // ------------------------------------------------------------
    // Serial feed across to the bit clock domain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end
        else
        begin
            ack_m <= ser_ack;
            ack_s <= ack_m;
        end
    end

    // A new pair is offered only once the last one was taken
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ser_req <= 1'b0;
            ser_left <= CAP_RST;
            ser_right <= CAP_RST;
        end
        else if (ser_req == ack_s)
        begin
            ser_left <= cap[2];
            ser_right <= cap[3];
            ser_req <= !ser_req;
        end
    end

    dnc_serial_out u_serial_out (
        .bclk_i(bclk_i),
        .lrclk_i(lrclk_i),
        .rst_n_i(rst_n_i),
        .left_i(ser_left),
        .right_i(ser_right),
        .req_i(ser_req),
        .ack_o(ser_ack),
        .sdo_o(capture_serial_output_o)
    );

endmodule : dnc_capture

// ==== tb/dnc_capture_asserts.sv ====
// Port checker of the data capture unit.
// Assumes it is bound to dnc_capture and sees only its ports.
`timescale 1ns/1ns
module dnc_capture_asserts
(
    // Core clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // SPI pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_o,
    // Serial link
    input wire logic bclk_i,
    input wire logic lrclk_i,
    input wire logic capture_serial_output_o
);
    // ------------------------------------------------------------
    // Slot bit counter, restarted where the design sees a new slot
    // ------------------------------------------------------------
    logic lr_seen;
    logic [5:0] slot_bit;
    always_ff @(negedge bclk_i)
    begin
        lr_seen <= lrclk_i;
        if (lrclk_i != lr_seen)
            slot_bit <= 6'h01;
        else if (slot_bit != 6'h3F)
            slot_bit <= slot_bit + 6'h01;
    end
    sequence cs_idle;
        spi_cs_n_i [*5];
    endsequence
    sequence cs_held;
        !spi_cs_n_i [*5];
    endsequence
    a_oe_off_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cs_idle |-> !spi_miso_oe_o) else $error("miso enable on while deselected");
    a_oe_on_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cs_held |-> spi_miso_oe_o) else $error("miso enable off while selected");
    a_oe_rise_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(spi_miso_oe_o) |-> !$past(spi_cs_n_i, 2)) else $error("miso enable rose early");
    a_oe_fall_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(spi_miso_oe_o) && $past(rst_n_i) |-> $past(spi_cs_n_i, 2))
        else $error("miso enable fell early");
    a_oe_holds_frame: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !spi_cs_n_i [*3] ##0 spi_miso_oe_o |=> spi_miso_oe_o)
        else $error("miso enable dropped in frame");
    a_miso_quiet_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        spi_sclk_i [*5] |-> $stable(spi_miso_o)) else $error("miso moved while clock high");
    a_reset_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> !spi_miso_oe_o && !spi_miso_o) else $error("pins busy after reset");
    a_slot_pad_zero: assert property (@(negedge bclk_i) disable iff (!rst_n_i)
        slot_bit >= 6'h19 |-> !capture_serial_output_o) else $error("slot tail not zero");
endmodule : dnc_capture_asserts

bind dnc_capture dnc_capture_asserts dnc_capture_asserts_i
(
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
    .bclk_i(bclk_i), .lrclk_i(lrclk_i),
    .capture_serial_output_o(capture_serial_output_o)
);

// ==== tb/dnc_link_model.sv ====
// Converter model on the capture serial link: frame sync and receiver.
// Assumes a free running bit clock, as audio links keep it running.
`timescale 1ns/1ns
module dnc_link_model
    import dnc_pkg::*;
(
    // Link clock and framing
    input wire logic bclk_i,
    output logic lrclk_o,
    // Serial data
    input wire logic sdo_i,
    // Received slots
    output logic [dnc_pkg::DATA_W-1:0] left_o,
    output logic [dnc_pkg::DATA_W-1:0] right_o
);
    logic [5:0] bit_cnt = 6'h00;
    logic [dnc_pkg::DATA_W-1:0] shift_q;
    // Frame sync moves on the falling edge, low half is the left slot
    always @(negedge bclk_i)
    begin
        bit_cnt <= bit_cnt + 6'h01;
    end
    assign lrclk_o = bit_cnt[5];
    // One bit of delay after the slot edge, then 24 bits MSB first
    always @(posedge bclk_i)
    begin
        if (bit_cnt[4:0] >= 5'h01 && bit_cnt[4:0] <= 5'h18)
            shift_q <= {shift_q[DATA_W-2:0], sdo_i};
        if (bit_cnt[4:0] == 5'h19 && !bit_cnt[5])
            left_o <= shift_q;
        if (bit_cnt[4:0] == 5'h19 && bit_cnt[5])
            right_o <= shift_q;
    end
endmodule : dnc_link_model

// ==== tb/dnc_capture_tb.sv ====
// Self-checking bench of the data capture unit.
// Assumes a 50 MHz core clock and a 64 ns bit clock of unrelated phase.
`timescale 1ns/1ns
module dnc_capture_tb;
    import dnc_pkg::*;
    logic ref_clk = 1'b0;
    logic bclk = 1'b0;
    logic rst_n = 1'b0;
    logic step_valid = 1'b0;
    logic [STEP_W-1:0] pc = 9'h000;
    logic [DATA_W-1:0] src [4];
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic mosi = 1'b0;
    logic miso;
    logic lrclk;
    logic sdo;
    logic [DATA_W-1:0] left_w;
    logic [DATA_W-1:0] right_w;
    logic [8:0] steps [4] = '{9'h000, 9'h1FF, 9'h0A5, 9'h15A};
    int num_errors = 0;
    int n_checks = 0;

    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        #7;
        forever #32 bclk = ~bclk;
    end

    dnc_capture dnc_capture_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .step_valid_i(step_valid), .prog_counter_i(pc), .mult_product_i(src[0]),
        .decibel_conversion_result_i(src[1]), .multiplier_data_operand_i(src[2]),
        .multiplier_coefficient_operand_i(src[3]), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(), .bclk_i(bclk),
        .lrclk_i(lrclk), .capture_serial_output_o(sdo));
    dnc_link_model dnc_link_model_i (.bclk_i(bclk), .lrclk_o(lrclk), .sdo_i(sdo),
        .left_o(left_w), .right_o(right_w));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [23:0] srcval(input logic [1:0] k, input logic [8:0] p,
        input logic [5:0] salt);
        return {salt, k, p, ~p[6:0]};
    endfunction : srcval

    // Half periods of 5 core clocks leave room for the pin synchronisers
    task automatic spi(input logic [47:0] tx, input int nb, output logic [47:0] rx);
        rx = 48'h000000000000;
        cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int b = 0; b < nb * 8; b++)
        begin
            mosi = tx[47 - b];
            repeat (5) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (5) @(negedge ref_clk);
            rx[47 - b] = miso;
            sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask : spi

    task automatic wr(input logic [9:0] a, input logic [8:0] s, input logic [1:0] k);
        logic [47:0] rx;
        spi({6'h00, a, 5'h00, s, k, 16'h0000}, 4, rx);
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] pad, output logic [23:0] d);
        logic [47:0] rx;
        spi({5'h00, 1'b1, a, 32'h00000000}, 6, rx);
        pad = rx[31:24];
        d = rx[23:0];
    endtask : rd

    // A live sweep is always followed by a quiet one, which lowers the step
    // flag in its first time step; lowering it here as well would drive it
    // twice in that step.
    task automatic sweep(input logic v, input logic [5:0] salt);
        for (int p = 0; p < 512; p++)
        begin
            step_valid = v;
            pc = 9'(p);
            for (int k = 0; k < 4; k++)
                src[k] = srcval(2'(k), 9'(p), salt);
            @(negedge ref_clk);
        end
    endtask : sweep

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [23:0] got;
        logic [7:0] pad;
        logic [8:0] st [4];
        logic [1:0] sel [4];
        foreach (src[k])
            src[k] = 24'h000000;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (40) @(negedge ref_clk);
        for (int p = 0; p < 2; p++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                st[j] = (p == 0) ? steps[j] : ~steps[j];
                sel[j] = (p == 0) ? 2'(j) : 2'(3 - j);
                wr(CAP_HOST_ONE + 10'(j), st[j], sel[j]);
            end
            sweep(1'b1, 6'(p + 1));
            // Same steps again without a live program step: nothing may move
            sweep(1'b0, 6'h3F);
            for (int j = 0; j < 2; j++)
            begin
                rd(CAP_HOST_ONE + 10'(j), pad, got);
                chk("pad byte", 24'h000000, 24'(pad));
                chk("host capture", srcval(sel[j], st[j], 6'(p + 1)), got);
            end
            rd(CAP_SER_ONE, pad, got);
            chk("serial setup read", 24'h000000, got);
            repeat (600) @(negedge ref_clk);
            chk("left slot", srcval(sel[2], st[2], 6'(p + 1)), left_w);
            chk("right slot", srcval(sel[3], st[3], 6'(p + 1)), right_w);
        end
        final_report();
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
endmodule : dnc_capture_tb
